// >>> hw/pin_mux_pkg.sv
// Constants shared by the port C/D alternate function mux
package pin_mux_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned PORT_W     = 8;
  localparam int unsigned RELEASE_W  = 3;

  // ****************************************
  // Address release thresholds, port C bits 7..0
  // ****************************************
  localparam logic [RELEASE_W-1:0] REL_LIMIT_C7 = 3'h1;
  localparam logic [RELEASE_W-1:0] REL_LIMIT_C6 = 3'h2;
  localparam logic [RELEASE_W-1:0] REL_LIMIT_C5 = 3'h3;
  localparam logic [RELEASE_W-1:0] REL_LIMIT_C4 = 3'h4;
  localparam logic [RELEASE_W-1:0] REL_LIMIT_C3 = 3'h5;
  localparam logic [RELEASE_W-1:0] REL_LIMIT_C2 = 3'h6;
  localparam logic [RELEASE_W-1:0] REL_LIMIT_C1 = 3'h7;
  localparam logic [RELEASE_W-1:0] REL_LIMIT_C0 = 3'h7;

  // ****************************************
  // Pin positions
  // ****************************************
  localparam int unsigned PIN_TDI      = 7;
  localparam int unsigned PIN_TDO      = 6;
  localparam int unsigned PIN_TMS      = 5;
  localparam int unsigned PIN_TCK      = 4;
  localparam int unsigned PIN_RD       = 7;
  localparam int unsigned PIN_WR       = 6;
  localparam int unsigned PIN_OSC_OUT  = 5;
  localparam int unsigned PIN_OSC_IN   = 4;
  localparam int unsigned PIN_EXT_INTERRUPT1_IN     = 3;
  localparam int unsigned PIN_EXT_INTERRUPT0_IN     = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [PORT_W-1:0] PORT_RST = 8'h00;
  localparam logic [PORT_W-1:0] PIN_SYNC_RST = 8'h00;
  localparam logic [PORT_W-1:0] ALL_ONES = 8'hff;

endpackage : pin_mux_pkg

// >>> hw/pin_override_if.sv
// Interface bundling the per-pin override enables and values for one port
interface pin_override_if
  import pin_mux_pkg::*;
();
  logic [PORT_W-1:0] pullup_override_enable;
  logic [PORT_W-1:0] pullup_override_value;
  logic [PORT_W-1:0] direction_override_enable;
  logic [PORT_W-1:0] direction_override_value;
  logic [PORT_W-1:0] value_override_enable;
  logic [PORT_W-1:0] value_override_value;
  logic [PORT_W-1:0] input_enable_override_enable;
  logic [PORT_W-1:0] input_enable_override_value;

  modport source (
    output pullup_override_enable, pullup_override_value,
    output direction_override_enable, direction_override_value,
    output value_override_enable, value_override_value,
    output input_enable_override_enable, input_enable_override_value
  );
  modport sink (
    input pullup_override_enable, pullup_override_value,
    input direction_override_enable, direction_override_value,
    input value_override_enable, value_override_value,
    input input_enable_override_enable, input_enable_override_value
  );
endinterface : pin_override_if

// >>> hw/port_pin_driver.sv
// Generic 8-pin port stage: applies overrides and synchronises pin inputs
module port_pin_driver
  import pin_mux_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  pin_override_if.sink           ovr,
  input  wire logic [PORT_W-1:0] port_out_i,
  input  wire logic [PORT_W-1:0] port_dir_i,
  input  wire logic [PORT_W-1:0] pullup_req_i,
  input  wire logic [PORT_W-1:0] pin_in_i,
  input  wire logic [PORT_W-1:0] sleep_in_off_i,
  output logic      [PORT_W-1:0] pin_out_o,
  output logic      [PORT_W-1:0] pin_oe_o,
  output logic      [PORT_W-1:0] pin_pullup_o,
  output logic      [PORT_W-1:0] pin_sync_o
);

  logic [PORT_W-1:0] meta_q;
  logic [PORT_W-1:0] sync_q;
  logic [PORT_W-1:0] in_en;
  logic [PORT_W-1:0] out_d;
  logic [PORT_W-1:0] oe_d;
  logic [PORT_W-1:0] pu_d;

  // ****************************************
  // Override selection
  // ****************************************
  // override replaces register
  always_comb begin
    oe_d  = (ovr.direction_override_enable & ovr.direction_override_value) |
            (~ovr.direction_override_enable & port_dir_i);
    out_d = (ovr.value_override_enable & ovr.value_override_value) |
            (~ovr.value_override_enable & port_out_i);
    pu_d  = (ovr.pullup_override_enable & ovr.pullup_override_value) |
            (~ovr.pullup_override_enable & pullup_req_i & ~oe_d);
    in_en = (ovr.input_enable_override_enable & ovr.input_enable_override_value) |
            (~ovr.input_enable_override_enable & ~sleep_in_off_i);
  end

  // Registered pads cannot glitch on override changes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_out_o    <= PORT_RST;
      pin_oe_o     <= PORT_RST;
      pin_pullup_o <= PORT_RST;
    end else begin
      pin_out_o    <= out_d;
      pin_oe_o     <= oe_d;
      pin_pullup_o <= pu_d;
    end
  end

  // ****************************************
  // Input synchroniser
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= PIN_SYNC_RST;
      sync_q <= PIN_SYNC_RST;
    end else begin
      meta_q <= pin_in_i;
      sync_q <= meta_q;
    end
  end

  // Disabled inputs read zero, so sleep logic cannot leak a floating pin
  assign pin_sync_o = sync_q & in_en;

endmodule : port_pin_driver

// >>> hw/port_c_d_alt_function_mux.sv
// Alternate function mux for port C and port D pins
// How it works
// - TAP enabled: port C bit 5 is mode select input only
// - TAP enabled: port C bit 4 is test clock input only
// - Port C 7..4 drive address 15..12 when release setting below 1..4 and TAP disabled
// - Port C 3..0 drive address 11..8 when release setting below 5,6,7,7
// - Port C input forced on by group and pin mask, or TAP for 7..4
// - Synchronised port C pin n goes to pin-change input n
// - Port D bit 7 carries memory read strobe when memory enabled
// - Port D bit 6 carries memory write strobe when memory enabled
// - Timer 2 async: port D bit 5 becomes oscillator output
// - Timer 2 async: port D bit 4 becomes oscillator input
// - Port D bit 5 outputs timer 1 compare A when direction set
// - Port D bit 4 clock of USART0: direction picks drive or receive
// - Port D bit 4 outputs timer 3 compare A; USART0 clock wins
// - Port D bit 3 feeds external interrupt 1
// - Port D bit 3 feeds timer 3 capture
// - Port D bit 2 feeds external interrupt 0
// - Port D bit 2 clock of USART1: direction picks output or input
// - TAP enabled: port C bit 6 drives serial test data out while shifting
// - TAP enabled: pull-ups on data in, mode select, clock stay on
module port_c_d_alt_function_mux
  import pin_mux_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  // Configuration
  input  wire logic                 ext_memory_enable_i,
  input  wire logic [RELEASE_W-1:0] address_release_setting_i,
  input  wire logic                 test_port_enable_i,
  input  wire logic                 pin_change_group_enable_i,
  input  wire logic [PORT_W-1:0]    pin_change_mask_i,
  input  wire logic                 timer2_async_select_i,
  input  wire logic                 pullup_disable_i,
  // General port registers
  input  wire logic [PORT_W-1:0]    portc_out_i,
  input  wire logic [PORT_W-1:0]    portc_dir_i,
  input  wire logic [PORT_W-1:0]    portd_out_i,
  input  wire logic [PORT_W-1:0]    portd_dir_i,
  input  wire logic [PORT_W-1:0]    sleep_in_off_i,
  // Peripheral sources
  input  wire logic [PORT_W-1:0]    ext_address_high_i,
  input  wire logic                 ext_read_strobe_i,
  input  wire logic                 ext_write_strobe_i,
  input  wire logic                 test_data_out_i,
  input  wire logic                 test_shift_active_i,
  input  wire logic                 timer1_compare_a_enable_i,
  input  wire logic                 timer1_compare_a_out_i,
  input  wire logic                 timer3_compare_a_enable_i,
  input  wire logic                 timer3_compare_a_out_i,
  input  wire logic                 usart0_sync_mode_i,
  input  wire logic                 usart0_ext_clock_i,
  input  wire logic                 usart1_sync_mode_i,
  input  wire logic                 usart1_ext_clock_i,
  input  wire logic                 ext_interrupt0_enable_i,
  input  wire logic                 ext_interrupt1_enable_i,
  // Pins
  input  wire logic [PORT_W-1:0]    portc_pin_i,
  input  wire logic [PORT_W-1:0]    portd_pin_i,
  output logic      [PORT_W-1:0]    portc_pin_o,
  output logic      [PORT_W-1:0]    portc_pin_oe_o,
  output logic      [PORT_W-1:0]    portc_pullup_o,
  output logic      [PORT_W-1:0]    portd_pin_o,
  output logic      [PORT_W-1:0]    portd_pin_oe_o,
  output logic      [PORT_W-1:0]    portd_pullup_o,
  // Outputs to peripherals
  output logic      [PORT_W-1:0]    pin_change_input_o,
  output logic                      test_mode_select_o,
  output logic                      test_clock_o,
  output logic                      test_data_in_o,
  output logic                      timer_osc_attach_o,
  output logic                      usart0_ext_clock_in_o,
  output logic                      usart1_ext_clock_in_o,
  output logic                      ext_interrupt0_in_o,
  output logic                      ext_interrupt1_in_o,
  output logic                      timer3_capture_in_o
);

  pin_override_if ovr_c ();
  pin_override_if ovr_d ();

  logic [PORT_W-1:0] addr_own;
  logic [PORT_W-1:0] sync_c;
  logic [PORT_W-1:0] sync_d;
  logic [PORT_W-1:0] pullup_req_c;
  logic [PORT_W-1:0] pullup_req_d;
  logic              tap;
  logic              usart0_clk_out;
  logic              usart1_clk_out;
  logic              osc_attach_q;

  // Memory owns an address pin while release setting is below its limit
  function automatic logic addr_owned(input logic en, input logic [RELEASE_W-1:0] rel,
                                      input logic [RELEASE_W-1:0] lim);
    addr_owned = en & (rel < lim);
  endfunction

  assign tap = test_port_enable_i;
  assign pullup_req_c = portc_out_i & {PORT_W{~pullup_disable_i}};
  assign pullup_req_d = portd_out_i & {PORT_W{~pullup_disable_i}};

  // ****************************************
  // Port C address ownership
  // ****************************************
  // high address ownership
  always_comb begin
    addr_own[7] = addr_owned(ext_memory_enable_i, address_release_setting_i, REL_LIMIT_C7);
    addr_own[6] = addr_owned(ext_memory_enable_i, address_release_setting_i, REL_LIMIT_C6);
    addr_own[5] = addr_owned(ext_memory_enable_i, address_release_setting_i, REL_LIMIT_C5);
    addr_own[4] = addr_owned(ext_memory_enable_i, address_release_setting_i, REL_LIMIT_C4);
    addr_own[3] = addr_owned(ext_memory_enable_i, address_release_setting_i, REL_LIMIT_C3);
    addr_own[2] = addr_owned(ext_memory_enable_i, address_release_setting_i, REL_LIMIT_C2);
    addr_own[1] = addr_owned(ext_memory_enable_i, address_release_setting_i, REL_LIMIT_C1);
    addr_own[0] = addr_owned(ext_memory_enable_i, address_release_setting_i, REL_LIMIT_C0);
  end

  // ****************************************
  // Port C overrides
  // ****************************************
  always_comb begin
    ovr_c.pullup_override_enable    = addr_own;
    ovr_c.pullup_override_value     = PORT_RST;
    ovr_c.direction_override_enable = addr_own;
    ovr_c.direction_override_value  = addr_own;
    ovr_c.value_override_enable     = addr_own;
    ovr_c.value_override_value      = ext_address_high_i;
    ovr_c.input_enable_override_enable = {PORT_W{pin_change_group_enable_i}} & pin_change_mask_i;
    ovr_c.input_enable_override_value  = ALL_ONES;
    if (tap) begin
      ovr_c.direction_override_enable[PIN_TMS] = 1'b1;
      ovr_c.direction_override_value[PIN_TMS]  = 1'b0;
      ovr_c.direction_override_enable[PIN_TCK] = 1'b1;
      ovr_c.direction_override_value[PIN_TCK]  = 1'b0;
      ovr_c.direction_override_enable[PIN_TDI] = 1'b1;
      ovr_c.direction_override_value[PIN_TDI]  = 1'b0;
      ovr_c.pullup_override_enable[PIN_TDI] = 1'b1;
      ovr_c.pullup_override_value[PIN_TDI]  = 1'b1;
      ovr_c.pullup_override_enable[PIN_TMS] = 1'b1;
      ovr_c.pullup_override_value[PIN_TMS]  = 1'b1;
      ovr_c.pullup_override_enable[PIN_TCK] = 1'b1;
      ovr_c.pullup_override_value[PIN_TCK]  = 1'b1;
      ovr_c.pullup_override_enable[PIN_TDO] = 1'b1;
      ovr_c.pullup_override_value[PIN_TDO]  = 1'b0;
      // test data out, driven while shifting
      ovr_c.direction_override_enable[PIN_TDO] = 1'b1;
      ovr_c.direction_override_value[PIN_TDO]  = test_shift_active_i;
      ovr_c.value_override_enable[PIN_TDO]     = 1'b1;
      ovr_c.value_override_value[PIN_TDO]      = test_data_out_i;
      ovr_c.value_override_enable[PIN_TDI]     = 1'b0;
      ovr_c.value_override_enable[PIN_TMS]     = 1'b0;
      ovr_c.value_override_enable[PIN_TCK]     = 1'b0;
      ovr_c.input_enable_override_enable[PIN_TDI:PIN_TCK] = 4'hf;
    end
  end

  // ****************************************
  // Port D overrides
  // ****************************************
  assign usart0_clk_out = usart0_sync_mode_i & portd_dir_i[PIN_OSC_IN];
  assign usart1_clk_out = usart1_sync_mode_i & portd_dir_i[PIN_EXT_INTERRUPT0_IN];

  always_comb begin
    ovr_d.pullup_override_enable       = PORT_RST;
    ovr_d.pullup_override_value        = PORT_RST;
    ovr_d.direction_override_enable    = PORT_RST;
    ovr_d.direction_override_value     = PORT_RST;
    ovr_d.value_override_enable        = PORT_RST;
    ovr_d.value_override_value         = PORT_RST;
    ovr_d.input_enable_override_enable = PORT_RST;
    ovr_d.input_enable_override_value  = PORT_RST;
    ovr_d.pullup_override_enable[PIN_RD]    = ext_memory_enable_i;
    ovr_d.direction_override_enable[PIN_RD] = ext_memory_enable_i;
    ovr_d.direction_override_value[PIN_RD]  = 1'b1;
    ovr_d.value_override_enable[PIN_RD]     = ext_memory_enable_i;
    ovr_d.value_override_value[PIN_RD]      = ext_read_strobe_i;
    ovr_d.pullup_override_enable[PIN_WR]    = ext_memory_enable_i;
    ovr_d.direction_override_enable[PIN_WR] = ext_memory_enable_i;
    ovr_d.direction_override_value[PIN_WR]  = 1'b1;
    ovr_d.value_override_enable[PIN_WR]     = ext_memory_enable_i;
    ovr_d.value_override_value[PIN_WR]      = ext_write_strobe_i;
    // timer 1 compare A, direction bit gates the pin
    ovr_d.value_override_enable[PIN_OSC_OUT] = timer1_compare_a_enable_i;
    ovr_d.value_override_value[PIN_OSC_OUT]  = timer1_compare_a_out_i;
    ovr_d.value_override_enable[PIN_OSC_IN] = usart0_clk_out | timer3_compare_a_enable_i;
    ovr_d.value_override_value[PIN_OSC_IN]  = usart0_clk_out ? usart0_ext_clock_i
                                                             : timer3_compare_a_out_i;
    ovr_d.value_override_enable[PIN_EXT_INTERRUPT0_IN] = usart1_clk_out;
    ovr_d.value_override_value[PIN_EXT_INTERRUPT0_IN]  = usart1_ext_clock_i;
    ovr_d.input_enable_override_enable[PIN_EXT_INTERRUPT1_IN] = ext_interrupt1_enable_i;
    ovr_d.input_enable_override_value[PIN_EXT_INTERRUPT1_IN]  = 1'b1;
    ovr_d.input_enable_override_enable[PIN_EXT_INTERRUPT0_IN] = ext_interrupt0_enable_i;
    ovr_d.input_enable_override_value[PIN_EXT_INTERRUPT0_IN]  = 1'b1;
    if (timer2_async_select_i) begin
      ovr_d.pullup_override_enable[PIN_OSC_OUT]       = 1'b1;
      ovr_d.direction_override_enable[PIN_OSC_OUT]    = 1'b1;
      ovr_d.input_enable_override_enable[PIN_OSC_OUT] = 1'b1;
      ovr_d.pullup_override_enable[PIN_OSC_IN]        = 1'b1;
      ovr_d.direction_override_enable[PIN_OSC_IN]     = 1'b1;
      ovr_d.input_enable_override_enable[PIN_OSC_IN]  = 1'b1;
    end
  end

  // Flag lags one cycle, in step with the pads
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_attach_q <= 1'b0;
    end else begin
      osc_attach_q <= timer2_async_select_i;
    end
  end
  assign timer_osc_attach_o = osc_attach_q;

  // ****************************************
  // Port stages
  // ****************************************
  port_pin_driver u_port_c (
    .clk_i          (clk_i),
    .rst_b_i        (rst_b_i),
    .ovr            (ovr_c.sink),
    .port_out_i     (portc_out_i),
    .port_dir_i     (portc_dir_i),
    .pullup_req_i   (pullup_req_c),
    .pin_in_i       (portc_pin_i),
    .sleep_in_off_i (sleep_in_off_i),
    .pin_out_o      (portc_pin_o),
    .pin_oe_o       (portc_pin_oe_o),
    .pin_pullup_o   (portc_pullup_o),
    .pin_sync_o     (sync_c)
  );

  port_pin_driver u_port_d (
    .clk_i          (clk_i),
    .rst_b_i        (rst_b_i),
    .ovr            (ovr_d.sink),
    .port_out_i     (portd_out_i),
    .port_dir_i     (portd_dir_i),
    .pullup_req_i   (pullup_req_d),
    .pin_in_i       (portd_pin_i),
    .sleep_in_off_i (sleep_in_off_i),
    .pin_out_o      (portd_pin_o),
    .pin_oe_o       (portd_pin_oe_o),
    .pin_pullup_o   (portd_pullup_o),
    .pin_sync_o     (sync_d)
  );

  // ****************************************
  // Inputs to peripherals
  // ****************************************
  // pin-change inputs
  assign pin_change_input_o = sync_c;
  assign test_mode_select_o = tap & sync_c[PIN_TMS];
  // test clock feed; TAP logic samples this as its own clock
  assign test_clock_o       = tap & sync_c[PIN_TCK];
  assign test_data_in_o     = tap & sync_c[PIN_TDI];
  assign usart0_ext_clock_in_o = usart0_sync_mode_i & ~portd_dir_i[PIN_OSC_IN] &
                                 ~timer2_async_select_i & sync_d[PIN_OSC_IN];
  assign usart1_ext_clock_in_o = usart1_sync_mode_i & ~portd_dir_i[PIN_EXT_INTERRUPT0_IN] & sync_d[PIN_EXT_INTERRUPT0_IN];
  assign ext_interrupt0_in_o = sync_d[PIN_EXT_INTERRUPT0_IN];
  assign ext_interrupt1_in_o = sync_d[PIN_EXT_INTERRUPT1_IN];
  assign timer3_capture_in_o = sync_d[PIN_EXT_INTERRUPT1_IN];

endmodule : port_c_d_alt_function_mux

// >>> verification/pin_mux_sva.sv
// Assertion checker for the port C/D alternate function mux
module pin_mux_sva
  import pin_mux_pkg::*;
(
  input wire logic clk_i, rst_b_i, ext_memory_enable_i, test_port_enable_i, timer2_async_select_i,
  input wire logic test_shift_active_i, test_data_out_i, ext_read_strobe_i, ext_write_strobe_i,
  input wire logic timer1_compare_a_enable_i, timer1_compare_a_out_i, usart0_sync_mode_i, usart0_ext_clock_i,
  input wire logic test_mode_select_o, test_clock_o, ext_interrupt1_in_o, timer3_capture_in_o,
  input wire logic pin_change_group_enable_i,
  input wire logic [RELEASE_W-1:0] address_release_setting_i,
  input wire logic [PORT_W-1:0] portc_dir_i, portd_dir_i, sleep_in_off_i, ext_address_high_i, portc_pin_i,
  input wire logic [PORT_W-1:0] portd_pin_i, portc_pin_o, portc_pin_oe_o, portc_pullup_o, portd_pin_o,
  input wire logic [PORT_W-1:0] portd_pin_oe_o, portd_pullup_o, pin_change_input_o, pin_change_mask_i
);
  // ****************************************
  // Pads lag one cycle, inputs two
  // ****************************************
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  high_addr_drive_a : assert property (
    ext_memory_enable_i && !test_port_enable_i && address_release_setting_i < 3'h4 |=>
    portc_pin_oe_o[4] && !portc_pullup_o[4] && portc_pin_o[4] == $past(ext_address_high_i[4]))
    else $error("addr 12 wrong");
  low_addr_drive_a : assert property (
    ext_memory_enable_i && address_release_setting_i < 3'h5 |=>
    portc_pin_oe_o[3] && !portc_pullup_o[3] && portc_pin_o[3] == $past(ext_address_high_i[3]))
    else $error("addr 11 wrong");
  addr_release_a : assert property (
    ext_memory_enable_i && address_release_setting_i == 3'h7 && !portc_dir_i[0] |=> !portc_pin_oe_o[0])
    else $error("released pin driven");
  strobes_drive_a : assert property (
    ext_memory_enable_i |=> portd_pin_oe_o[7:6] == 2'h3 && portd_pullup_o[7:6] == 2'h0 &&
    portd_pin_o[7:6] == {$past(ext_read_strobe_i), $past(ext_write_strobe_i)})
    else $error("strobes wrong");
  osc_detach_a : assert property (
    timer2_async_select_i |=> portd_pin_oe_o[5:4] == 2'h0 && portd_pullup_o[5:4] == 2'h0)
    else $error("osc pins attached");
  compare1_out_a : assert property (
    !timer2_async_select_i && portd_dir_i[5] && timer1_compare_a_enable_i |=>
    portd_pin_oe_o[5] && portd_pin_o[5] == $past(timer1_compare_a_out_i))
    else $error("compare 1 wrong");
  usart0_clock_a : assert property (
    !timer2_async_select_i && portd_dir_i[4] && usart0_sync_mode_i |=>
    portd_pin_oe_o[4] && portd_pin_o[4] == $past(usart0_ext_clock_i))
    else $error("usart0 clock wrong");
  tap_inputs_a : assert property (
    test_port_enable_i [*3] |-> test_mode_select_o == $past(portc_pin_i[5], 2) &&
    test_clock_o == $past(portc_pin_i[4], 2))
    else $error("tap inputs wrong");
  tap_pullup_a : assert property (
    test_port_enable_i |=> portc_pullup_o[7] && portc_pullup_o[5] && portc_pullup_o[4])
    else $error("tap pull-ups off");
  test_out_a : assert property (
    test_port_enable_i && test_shift_active_i |=> portc_pin_oe_o[6] && portc_pin_o[6] == $past(test_data_out_i))
    else $error("TDO wrong");
  ext_interrupt1_in_path_a : assert property (
    !sleep_in_off_i[3] [*3] |-> ext_interrupt1_in_o == $past(portd_pin_i[3], 2) &&
    timer3_capture_in_o == ext_interrupt1_in_o)
    else $error("ext_interrupt1_in path wrong");
  pin_change_a : assert property (
    (pin_change_group_enable_i && pin_change_mask_i[2]) [*3] |-> pin_change_input_o[2] == $past(portc_pin_i[2], 2))
    else $error("pin change wrong");

  cover property (ext_memory_enable_i && address_release_setting_i == 3'h0);
  cover property (test_port_enable_i && test_shift_active_i);
  cover property (usart0_sync_mode_i && portd_dir_i[4]);
endmodule // pin_mux_sva

bind port_c_d_alt_function_mux pin_mux_sva sva_u (.*);

// >>> verification/pin_partner.sv
// Behavioural model of the peripherals, memory and pads around the mux
module pin_partner
  import pin_mux_pkg::*;
(
  input  wire logic              clk_i,
  output logic      [PORT_W-1:0] ext_address_high_i, portc_pin_i, portd_pin_i,
  output logic                   ext_read_strobe_i, ext_write_strobe_i, test_data_out_i, timer1_compare_a_out_i,
  output logic                   timer3_compare_a_out_i, usart0_ext_clock_i, usart1_ext_clock_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Sources move every cycle so a stale capture cannot match by luck
  // ****************************************
  logic [15:0] cnt_q = 16'h0000, mix;
  always @(posedge clk_i) cnt_q <= cnt_q + 16'h0001;
  assign mix = cnt_q * 16'h9e37;
  assign {ext_address_high_i, portc_pin_i, portd_pin_i} = {mix[15:8] ^ mix[7:0], mix[11:4], mix[14:7]};
  assign {ext_read_strobe_i, ext_write_strobe_i, test_data_out_i, timer1_compare_a_out_i, timer3_compare_a_out_i,
          usart0_ext_clock_i, usart1_ext_clock_i} = {mix[3], mix[5], mix[7], mix[9], mix[11], mix[13], mix[15]};
endmodule // pin_partner

// >>> verification/testbench.sv
// Self-checking testbench for the port C/D alternate function mux
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench
  import pin_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_b_i = 1'b0;
  logic ext_memory_enable_i, test_port_enable_i, pin_change_group_enable_i, timer2_async_select_i;
  logic pullup_disable_i, test_shift_active_i, timer1_compare_a_enable_i, timer3_compare_a_enable_i;
  logic usart0_sync_mode_i, usart1_sync_mode_i, ext_interrupt0_enable_i, ext_interrupt1_enable_i;
  logic [RELEASE_W-1:0] address_release_setting_i;
  logic [PORT_W-1:0] pin_change_mask_i, portc_out_i, portc_dir_i, portd_out_i, portd_dir_i, sleep_in_off_i;
  logic [PORT_W-1:0] ext_address_high_i, portc_pin_i, portd_pin_i, portc_pin_o, portc_pin_oe_o, portc_pullup_o;
  logic [PORT_W-1:0] portd_pin_o, portd_pin_oe_o, portd_pullup_o, pin_change_input_o;
  logic ext_read_strobe_i, ext_write_strobe_i, test_data_out_i, timer1_compare_a_out_i, timer3_compare_a_out_i;
  logic usart0_ext_clock_i, usart1_ext_clock_i, test_mode_select_o, test_clock_o, test_data_in_o;
  logic timer_osc_attach_o, usart0_ext_clock_in_o, usart1_ext_clock_in_o, ext_interrupt0_in_o;
  logic ext_interrupt1_in_o, timer3_capture_in_o;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  // History: 1 is one cycle back, 2 is two
  logic [PORT_W-1:0] pc1, pc2, pd1, pd2, ad1, m;
  logic [6:0] sr1;
  logic [RELEASE_W-1:0] lim [8];

  port_c_d_alt_function_mux dut_u (.*);
  pin_partner partner_u (.*);

  initial forever #5 clk_i = ~clk_i;
  // Run takes about 50 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 500) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Testbench-driven inputs only ever move at the falling edge; partner sources move at the rising edge
  task automatic step(input int n);
    repeat (n) begin
      {pc2, pc1, pd2, pd1, ad1} = {pc1, portc_pin_i, pd1, portd_pin_i, ext_address_high_i};
      sr1 = {ext_read_strobe_i, ext_write_strobe_i, test_data_out_i, timer1_compare_a_out_i,
             timer3_compare_a_out_i, usart0_ext_clock_i, usart1_ext_clock_i};
      @(negedge clk_i);
    end
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {ext_memory_enable_i, test_port_enable_i, pin_change_group_enable_i, timer2_async_select_i,
     pullup_disable_i, test_shift_active_i, timer1_compare_a_enable_i, timer3_compare_a_enable_i,
     usart0_sync_mode_i, usart1_sync_mode_i, ext_interrupt0_enable_i, ext_interrupt1_enable_i,
     address_release_setting_i, pin_change_mask_i, portc_dir_i, portd_dir_i, sleep_in_off_i} = '0;
    {portc_out_i, portd_out_i} = 16'hffff;
    lim = '{REL_LIMIT_C0, REL_LIMIT_C1, REL_LIMIT_C2, REL_LIMIT_C3,
            REL_LIMIT_C4, REL_LIMIT_C5, REL_LIMIT_C6, REL_LIMIT_C7};
    step(4);
    `CHK("reset pads", 24'h000000, {portc_pin_oe_o, portc_pullup_o, portd_pullup_o});
    rst_b_i = 1'b1;
    step(2);
    $display("test reset done");
    ext_memory_enable_i = 1'b1;
    for (int r = 0; r < 8; r++) begin
      address_release_setting_i = r[2:0];
      for (int b = 0; b < 8; b++) m[b] = (r[2:0] < lim[b]);
      step(2);
      `CHK("addr oe", m, portc_pin_oe_o);
      `CHK("addr value", ad1 & m, portc_pin_o & m);
      `CHK("addr pullup", ~m, portc_pullup_o);
    end
    $display("test address release done");
    ext_memory_enable_i = 1'b0;
    sleep_in_off_i = 8'hff;
    pin_change_group_enable_i = 1'b1;
    pin_change_mask_i = 8'h3c;
    step(3);
    repeat (3) begin
      step(1);
      `CHK("pin change", pc2 & 8'h3c, pin_change_input_o);
    end
    // Test port alone forces upper inputs on
    pin_change_group_enable_i = 1'b0;
    {test_port_enable_i, test_shift_active_i, pullup_disable_i} = 3'h7;
    step(3);
    repeat (3) begin
      step(1);
      `CHK("tap pin change", pc2 & 8'hf0, pin_change_input_o);
      `CHK("tap inputs", {pc2[5], pc2[4], pc2[7]}, {test_mode_select_o, test_clock_o, test_data_in_o});
      `CHK("tap data out", {1'b1, sr1[4]}, {portc_pin_oe_o[6], portc_pin_o[6]});
      `CHK("tap pullups", 8'hb0, portc_pullup_o);
    end
    $display("test port C done");
    {test_port_enable_i, test_shift_active_i, pullup_disable_i} = 3'h0;
    sleep_in_off_i = 8'h00;
    {ext_memory_enable_i, timer2_async_select_i, timer1_compare_a_enable_i} = 3'h7;
    portd_dir_i = 8'h30;
    step(2);
    repeat (2) begin
      step(1);
      `CHK("strobe oe", 4'hc, portd_pin_oe_o[7:4]);
      `CHK("strobes", sr1[6:5], portd_pin_o[7:6]);
      `CHK("strobe pullups", 4'h0, portd_pullup_o[7:4]);
      `CHK("osc attach", 1'b1, timer_osc_attach_o);
    end
    timer2_async_select_i = 1'b0;
    timer3_compare_a_enable_i = 1'b1;
    step(2);
    repeat (2) begin
      step(1);
      `CHK("compare outs", {2'h3, sr1[3:2]}, {portd_pin_oe_o[5:4], portd_pin_o[5:4]});
    end
    {usart0_sync_mode_i, usart1_sync_mode_i} = 2'h3;
    portd_dir_i = 8'h34;
    step(2);
    repeat (2) begin
      step(1);
      `CHK("usart clocks out", {1'b1, sr1[1], sr1[0]}, {portd_pin_oe_o[2], portd_pin_o[4], portd_pin_o[2]});
    end
    // Interrupt enables force disabled inputs on
    portd_dir_i = 8'h00;
    sleep_in_off_i = 8'hef;
    {ext_interrupt0_enable_i, ext_interrupt1_enable_i} = 2'h3;
    step(3);
    repeat (3) begin
      step(1);
      `CHK("usart clocks in", {pd2[4], pd2[2]}, {usart0_ext_clock_in_o, usart1_ext_clock_in_o});
      `CHK("ext inputs", {pd2[3], pd2[3], pd2[2]}, {ext_interrupt1_in_o, timer3_capture_in_o, ext_interrupt0_in_o});
      `CHK("compare idle", 2'h0, portd_pin_oe_o[5:4]);
    end
    $display("test port D done");
    wrap_up();
  end
endmodule // testbench
